// File: logic/ulmc_core.sv
// uart line format and modem control with minimal serial engine and register port
//
// Functional notes
// R1 - divisor_access_select steers low offsets to divisor
// R2 - break holds transmit output at space
// R3 - break reaches the receive path only through loopback
// R4 - stick parity: fixed bit, inverse of even select
// R5 - normal parity: even or odd ones count
// R6 - parity_enable inserts and checks a parity bit
// R7 - parity bit sits between data and stop
// R8 - stop_bit_count zero sends exactly one stop
// R9 - one and half or two stop bits
// R10 - receiver checks only the first stop bit
// R11 - character length codes five through eight bits
// R12 - loopback returns transmitted characters to receiver
// R13 - loopback maps dtr rts aux gate to status
// R14 - irq gate drives or releases host_interrupt_line
// R15 - aux_output_one only feeds looped ring status
// R16 - rts follows modem control bit one
// R17 - dtr follows modem control bit zero
// R18 - parity mismatch flagged, cleared by status read
// R19 - upper modem bits zero, registers reset clear except divisor, which resets to one
// R20 - loopback idles output and isolates modem inputs
`timescale 1ns/1ps

module ulmc_core
  import ulmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rdata,
  // serial line
  input wire logic serial_in,
  output logic serial_out,
  // modem pins, active low
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic dcd_n,
  output logic rts_n,
  output logic dtr_n,
  // host interrupt line, three-state
  input wire logic irq_req,
  output logic host_interrupt_line_o,
  output logic host_interrupt_line_oe_n,
  // state to neighbouring logic
  output logic divisor_access_select,
  output logic loopback
);

  ulmc_req_s req;
  assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};

  // registers
  logic [7:0] lfc_r;
  logic [7:0] mlc_r;
  logic [7:0] ier_r;
  logic [7:0] scr_r;
  logic [15:0] div_r;
  ulmc_lfc_s lfc;
  assign lfc = ulmc_lfc_s'(lfc_r);

  wire div_sel = lfc.divisor_access_select;
  wire loop_on = mlc_r[MLC_LOOP];
  wire [1:0] wls = {lfc.char_length_bit_high, lfc.char_length_bit_low};
  wire [1:0] len_sh = 2'd3 - wls;

  // address decode
  wire hit_data = (req.addr == OFS_DATA);
  wire hit_ier = (req.addr == OFS_IER);
  wire wr_thr = req.wr & hit_data & ~div_sel; // [R1]
  wire wr_dll = req.wr & hit_data & div_sel; // [R1]
  wire wr_ier = req.wr & hit_ier & ~div_sel; // [R1]
  wire wr_dlm = req.wr & hit_ier & div_sel; // [R1]
  wire wr_lfc = req.wr & (req.addr == OFS_LFC);
  wire wr_mlc = req.wr & (req.addr == OFS_MLC);
  wire wr_scr = req.wr & (req.addr == OFS_SCR);
  wire rd_rbr = req.rd & hit_data & ~div_sel; // [R1]
  wire rd_lst = req.rd & (req.addr == OFS_LST);
  wire rd_mst = req.rd & (req.addr == OFS_MST);

  // parity of a character, masked to the configured length
  function automatic logic par_of(input logic [7:0] d, input ulmc_lfc_s f,
                                  input logic [1:0] sh);
    logic [7:0] m;
    m = d & (8'hff >> sh); // [R11]
    if (f.stick_parity) begin
      par_of = ~f.even_parity_select; // [R4]
    end else begin
      par_of = f.even_parity_select ? ^m : ~^m; // [R5]
    end
  endfunction

  // input synchronisers
  logic [1:0] sin_s_r;
  logic [1:0] cts_s_r;
  logic [1:0] dsr_s_r;
  logic [1:0] ri_s_r;
  logic [1:0] dcd_s_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sin_s_r <= 2'b11;
      cts_s_r <= 2'b11;
      dsr_s_r <= 2'b11;
      ri_s_r <= 2'b11;
      dcd_s_r <= 2'b11;
    end else begin
      sin_s_r <= {sin_s_r[0], serial_in};
      cts_s_r <= {cts_s_r[0], cts_n};
      dsr_s_r <= {dsr_s_r[0], dsr_n};
      ri_s_r <= {ri_s_r[0], ri_n};
      dcd_s_r <= {dcd_s_r[0], dcd_n};
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfc_r <= LFC_RST; // [R19]
      mlc_r <= MLC_RST; // [R19]
      ier_r <= IER_RST;
      scr_r <= SCR_RST;
      div_r <= DIV_RST;
    end else begin
      if (wr_lfc) lfc_r <= req.wdata;
      if (wr_mlc) mlc_r <= req.wdata & MLC_WR_MASK; // [R19]
      if (wr_ier) ier_r <= {4'h0, req.wdata[3:0] & IER_MASK};
      if (wr_scr) scr_r <= req.wdata;
      if (wr_dll) div_r[7:0] <= req.wdata;
      if (wr_dlm) div_r[15:8] <= req.wdata;
    end
  end

  // 16x sample tick from divisor
  logic [15:0] div_cnt_r;
  logic tick_r;
  wire [15:0] div_last = (div_r == 16'h0000) ? 16'h0000 : div_r - 16'h0001;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_cnt_r >= div_last) begin
      div_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // transmitter
  ulmc_fr_e tx_st_r;
  logic [5:0] tx_tick_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic tx_par_r;
  logic [7:0] thr_r;
  logic thr_full_r;

  wire [5:0] stop_ticks = !lfc.stop_bit_count ? TICKS_STOP_1 : // [R8]
                          (wls == 2'b00) ? TICKS_STOP_15 : TICKS_STOP_2; // [R9]
  wire [5:0] tx_span = (tx_st_r == FR_STOP) ? stop_ticks : TICKS_BIT;
  wire tx_bit_end = tick_r & (tx_tick_r == tx_span - 6'h01);
  wire tx_load = (tx_st_r == FR_IDLE) & thr_full_r;
  wire [2:0] last_bit = {1'b1, wls};

  logic tx_frame;
  always_comb begin
    case (tx_st_r)
      FR_IDLE: tx_frame = 1'b1;
      FR_START: tx_frame = 1'b0;
      FR_DATA: tx_frame = tx_sh_r[0];
      FR_PARITY: tx_frame = tx_par_r; // [R7]
      FR_STOP: tx_frame = 1'b1;
      default: tx_frame = 1'b1;
    endcase
  end
  wire tx_line = tx_frame & ~lfc.break_ctl; // [R2]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_r <= FR_IDLE;
      tx_tick_r <= 6'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
    end else if (tx_load) begin
      tx_st_r <= FR_START;
      tx_tick_r <= 6'h00;
      tx_bit_r <= 3'h0;
      tx_sh_r <= thr_r;
      tx_par_r <= par_of(thr_r, lfc, len_sh);
    end else if (tx_st_r != FR_IDLE && tick_r) begin
      tx_tick_r <= tx_bit_end ? 6'h00 : tx_tick_r + 6'h01;
      if (tx_bit_end) begin
        case (tx_st_r)
          FR_START: begin
            tx_st_r <= FR_DATA;
          end
          FR_DATA: begin
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == 3'd4 + {1'b0, wls}) begin // [R11]
              tx_st_r <= lfc.parity_enable ? FR_PARITY : FR_STOP; // [R6] [R7]
            end
          end
          FR_PARITY: begin
            tx_st_r <= FR_STOP;
          end
          default: begin
            tx_st_r <= FR_IDLE;
          end
        endcase
      end
    end
  end

  // holding buffer: a write in the load cycle keeps it full
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thr_r <= 8'h00;
      thr_full_r <= 1'b0;
    end else begin
      if (wr_thr) thr_r <= req.wdata;
      thr_full_r <= wr_thr | (thr_full_r & ~tx_load);
    end
  end

  // receiver, fed from the pin or the looped transmit line
  wire rx_line = loop_on ? tx_line : sin_s_r[1]; // [R12] [R20] [R3]
  ulmc_fr_e rx_st_r;
  logic [3:0] rx_tick_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r;
  wire rx_mid_start = tick_r & (rx_tick_r == TICK_MID);
  wire rx_mid = tick_r & (rx_tick_r == TICK_LAST);
  wire rx_done = (rx_st_r == FR_STOP) & rx_mid; // [R10]
  wire [7:0] rx_data = rx_sh_r >> len_sh; // [R11]
  wire rx_par_bad = lfc.parity_enable & (rx_par_r != par_of(rx_data, lfc, len_sh)); // [R18]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_st_r <= FR_IDLE;
      rx_tick_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
    end else begin
      case (rx_st_r)
        FR_IDLE: begin
          rx_tick_r <= 4'h0;
          rx_bit_r <= 3'h0;
          if (!rx_line) rx_st_r <= FR_START;
        end
        FR_START: begin
          if (tick_r) rx_tick_r <= rx_mid_start ? 4'h0 : rx_tick_r + 4'h1;
          if (rx_mid_start) rx_st_r <= rx_line ? FR_IDLE : FR_DATA;
        end
        FR_DATA: begin
          if (tick_r) rx_tick_r <= rx_tick_r + 4'h1;
          if (rx_mid) begin
            rx_sh_r <= {rx_line, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == last_bit) begin // [R11]
              rx_st_r <= lfc.parity_enable ? FR_PARITY : FR_STOP; // [R6] [R7]
            end
          end
        end
        FR_PARITY: begin
          if (tick_r) rx_tick_r <= rx_tick_r + 4'h1;
          if (rx_mid) begin
            rx_par_r <= rx_line; // [R6]
            rx_st_r <= FR_STOP;
          end
        end
        FR_STOP: begin
          if (tick_r) rx_tick_r <= rx_tick_r + 4'h1;
          if (rx_mid) rx_st_r <= FR_IDLE; // [R10]
        end
        default: begin
          rx_st_r <= FR_IDLE;
        end
      endcase
    end
  end

  // receive buffer and line status flags, set wins over read clear
  logic [7:0] rbr_r;
  logic dr_r;
  logic oe_r;
  logic pe_r;
  logic fe_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rbr_r <= 8'h00;
      dr_r <= 1'b0;
      oe_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
    end else begin
      if (rx_done) rbr_r <= rx_data; // [R12]
      dr_r <= rx_done | (dr_r & ~rd_rbr);
      oe_r <= (rx_done & dr_r & ~rd_rbr) | (oe_r & ~rd_lst);
      pe_r <= (rx_done & rx_par_bad) | (pe_r & ~rd_lst); // [R18]
      fe_r <= (rx_done & ~rx_line) | (fe_r & ~rd_lst); // [R10]
    end
  end

  wire thre = ~thr_full_r;
  wire temt = thre & (tx_st_r == FR_IDLE);
  wire [7:0] lst_val = {1'b0, temt, thre, 1'b0, fe_r, pe_r, oe_r, dr_r};

  // modem status: looped control bits or isolated pins
  wire [3:0] pin_st = {~dcd_s_r[1], ~ri_s_r[1], ~dsr_s_r[1], ~cts_s_r[1]};
  wire [3:0] loop_st = {mlc_r[MLC_IRQ_GATE], mlc_r[MLC_AUX1],
                        mlc_r[MLC_DTR], mlc_r[MLC_RTS]}; // [R13] [R15]
  wire [3:0] cur_st = loop_on ? loop_st : pin_st; // [R13] [R20]
  logic [3:0] prev_st_r;
  logic [3:0] delta_r;
  wire [3:0] chg = cur_st ^ prev_st_r;
  wire [3:0] delta_set = {chg[3], prev_st_r[2] & ~cur_st[2], chg[1], chg[0]};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_st_r <= 4'h0;
      delta_r <= 4'h0;
    end else begin
      prev_st_r <= cur_st;
      delta_r <= delta_set | (delta_r & {4{~rd_mst}});
    end
  end
  wire [7:0] mst_val = {cur_st, delta_r};

  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (req.addr)
      OFS_DATA: rd_mux = div_sel ? div_r[7:0] : rbr_r; // [R1]
      OFS_IER: rd_mux = div_sel ? div_r[15:8] : ier_r; // [R1]
      OFS_IIR: rd_mux = IIR_NONE;
      OFS_LFC: rd_mux = lfc_r;
      OFS_MLC: rd_mux = mlc_r; // [R19]
      OFS_LST: rd_mux = lst_val;
      OFS_MST: rd_mux = mst_val;
      OFS_SCR: rd_mux = scr_r;
      default: rd_mux = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      serial_out <= 1'b1;
      rts_n <= 1'b1;
      dtr_n <= 1'b1;
      host_interrupt_line_o <= 1'b0;
      host_interrupt_line_oe_n <= 1'b1;
      divisor_access_select <= 1'b0;
      loopback <= 1'b0;
    end else begin
      rdata <= req.rd ? rd_mux : 8'h00;
      serial_out <= loop_on ? 1'b1 : tx_line; // [R2] [R20]
      rts_n <= ~mlc_r[MLC_RTS]; // [R16]
      dtr_n <= ~mlc_r[MLC_DTR]; // [R17]
      host_interrupt_line_o <= irq_req;
      host_interrupt_line_oe_n <= ~mlc_r[MLC_IRQ_GATE]; // [R14]
      divisor_access_select <= div_sel;
      loopback <= loop_on;
    end
  end

endmodule

// File: pkg/ulmc_pkg.sv
// shared constants, field layouts and types for the uart line and modem control block
package ulmc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR = 3'h2;
  localparam logic [2:0] OFS_LFC = 3'h3;
  localparam logic [2:0] OFS_MLC = 3'h4;
  localparam logic [2:0] OFS_LST = 3'h5;
  localparam logic [2:0] OFS_MST = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;

  // modem_line_control field positions
  localparam int MLC_DTR = 0;
  localparam int MLC_RTS = 1;
  localparam int MLC_AUX1 = 2;
  localparam int MLC_IRQ_GATE = 3;
  localparam int MLC_LOOP = 4;
  localparam logic [7:0] MLC_WR_MASK = 8'h1f;

  // reset values
  localparam logic [7:0] LFC_RST = 8'h00;
  localparam logic [7:0] MLC_RST = 8'h00;
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] SCR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [7:0] IIR_NONE = 8'h01;
  localparam logic [3:0] IER_MASK = 4'hf;

  // timing in 16x sample ticks
  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [5:0] TICKS_STOP_1 = 6'h10;
  localparam logic [5:0] TICKS_STOP_15 = 6'h18;
  localparam logic [5:0] TICKS_STOP_2 = 6'h20;

  // line_format_control layout, msb first
  typedef struct packed {
    logic divisor_access_select;
    logic break_ctl;
    logic stick_parity;
    logic even_parity_select;
    logic parity_enable;
    logic stop_bit_count;
    logic char_length_bit_high;
    logic char_length_bit_low;
  } ulmc_lfc_s;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ulmc_req_s;

  // framing states, shared by both directions
  typedef enum logic [4:0] {
    FR_IDLE = 5'b00001,
    FR_START = 5'b00010,
    FR_DATA = 5'b00100,
    FR_PARITY = 5'b01000,
    FR_STOP = 5'b10000
  } ulmc_fr_e;

endpackage

// File: tb/tb.sv
// testbench for the line format and modem control block
`timescale 1ns/1ps
module tb
  import ulmc_pkg::*;
;
  localparam logic [7:0] TBL [4] = '{8'h03, 8'h1e, 8'h2b, 8'h3a};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ulmc_req_s req;
  logic [7:0] rdata;
  logic serial_in = 1'b1;
  logic serial_out;
  logic [3:0] mdm_n = 4'hf;
  logic irq_req = 1'b0;
  logic rd_seen = 1'b0;
  logic [15:0] e;
  logic [15:0] q[$];
  logic [7:0] l;
  logic [7:0] d;
  int n_errors = 0;
  int n_tests = 0;
  int seed = 71;
  int cyc = 0;

  ulmc_host host (.clk(clk), .req(req));
  ulmc_core uut (.clk(clk), .rst_n(rst_n), .addr(req.addr), .wdata(req.wdata),
    .wr_stb(req.wr), .rd_stb(req.rd), .rdata(rdata), .serial_in(serial_in),
    .serial_out(serial_out), .cts_n(mdm_n[0]), .dsr_n(mdm_n[1]), .ri_n(mdm_n[2]),
    .dcd_n(mdm_n[3]), .rts_n(), .dtr_n(), .irq_req(irq_req), .host_interrupt_line_o(),
    .host_interrupt_line_oe_n(), .divisor_access_select(), .loopback());

  always #10 clk = ~clk;

  task automatic chk(input logic [15:0] a, input logic [15:0] x);
    n_tests++;
    if (a !== x) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, a, x);
    end
  endtask

  // read results arrive one cycle after the strobe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_req <= 1'($random(seed));
    rd_seen <= req.rd;
    if (rd_seen) begin
      e = q.pop_front();
      chk(16'(rdata & e[15:8]), 16'(e[7:0]));
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic w(input logic [2:0] a, input logic [7:0] v);
    host.wr(a, v);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] x, input logic [7:0] m);
    q.push_back({m, x});
    host.rd(a);
  endtask
  task automatic mst(input logic [7:0] x);
    repeat (3) @(posedge clk);
    rd(OFS_MST, x, 8'hf0);
  endtask

  // start, data lsb first, optional parity, then mark
  function automatic logic [11:0] frame(input logic [7:0] lf, input logic [7:0] df,
                                         input logic bad);
    logic [11:0] f;
    logic [7:0] m;
    int n;
    n = 7 + lf[0];
    m = lf[0] ? df : {1'b0, df[6:0]};
    f = 12'hfff;
    f[0] = 1'b0;
    for (int k = 0; k < n; k++) begin
      f[k + 1] = m[k];
    end
    if (lf[3]) begin
      f[n + 1] = (lf[5] ? ~lf[4] : ~lf[4] ^ (^m)) ^ bad;
    end
    return f;
  endfunction

  task automatic tx_check(input logic [7:0] lt, input logic [7:0] dt);
    logic [11:0] f;
    int nb;
    int t0;
    int k;
    f = frame(lt, dt, 1'b0);
    nb = 8 + lt[0] + lt[3];
    w(OFS_LFC, lt);
    w(OFS_DATA, dt);
    for (k = 0; k < 100 && serial_out; k++) begin
      @(posedge clk);
    end
    t0 = cyc;
    w(OFS_DATA, ~dt);
    repeat (6) @(posedge clk);
    for (k = 0; k <= nb; k++) begin
      chk(16'(serial_out), 16'(f[k]));
      if (k < nb) begin
        repeat (16) @(posedge clk);
      end
    end
    for (k = 0; k < 100 && serial_out; k++) begin
      @(posedge clk);
    end
    // one idle cycle passes before the held byte is loaded
    chk(16'(cyc - t0), 16'(16 * (nb + 1 + lt[2]) + 1));
    repeat (200) @(posedge clk);
  endtask

  task automatic rx_check(input logic [7:0] lr, input logic [7:0] dr, input logic bad);
    logic [11:0] f;
    f = frame(lr, dr, bad);
    w(OFS_LFC, lr);
    for (int k = 0; k <= 8 + lr[0] + lr[3]; k++) begin
      serial_in <= f[k];
      repeat (16) @(posedge clk);
    end
    if (lr[6]) begin
      chk(16'(serial_out), 16'h0000);
    end
    rd(OFS_LST, {5'h00, bad, 2'b01}, 8'h0d);
    rd(OFS_DATA, lr[0] ? dr : {1'b0, dr[6:0]}, 8'hff);
    rd(OFS_LST, 8'h00, 8'h04);
  endtask

  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_LFC, 8'h00, 8'hff);
    rd(OFS_MLC, 8'h00, 8'hff);
    w(OFS_IER, 8'h0a);
    w(OFS_LFC, 8'h83);
    rd(OFS_DATA, 8'h01, 8'hff);
    rd(OFS_IER, 8'h00, 8'hff);
    w(OFS_LFC, 8'h03);
    rd(OFS_IER, 8'h0a, 8'hff);
    $display("test steering done");
    mdm_n <= 4'($random(seed));
    // let the new pin value land before the expectation is formed
    @(posedge clk);
    mst({~mdm_n, 4'h0});
    w(OFS_MLC, 8'hf0);
    rd(OFS_MLC, 8'h10, 8'hff);
    mst(8'h00);
    w(OFS_MLC, 8'hff);
    rd(OFS_MLC, 8'h1f, 8'hff);
    mst(8'hf0);
    w(OFS_MLC, 8'h15);
    mst(8'h60);
    w(OFS_DATA, 8'hc3);
    repeat (200) @(posedge clk);
    rd(OFS_LST, 8'h01, 8'h01);
    rd(OFS_DATA, 8'hc3, 8'hff);
    w(OFS_MLC, 8'h0a);
    $display("test loopback done");
    for (int i = 0; i < 6; i++) begin
      l = (i < 4) ? TBL[i] : (8'($random(seed)) & 8'h3f) | 8'h02;
      d = 8'($random(seed));
      tx_check(l, d);
      rx_check(l | (i == 1 ? 8'h40 : 8'h00), d, i[0] && l[3]);
      $display("test framing %0d done", i);
    end
    finish_test();
  end
endmodule

// File: tb/ulmc_host.sv
// host model driving the register port
`timescale 1ns/1ps
module ulmc_host
  import ulmc_pkg::*;
(
  // clock
  input wire logic clk,
  // register request
  output ulmc_req_s req
);
  initial req = '0;
  // one-cycle strobe, held with address and data to the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
  endtask
endmodule

// File: tb/ulmc_properties.sv
// assertions on the line format and modem control ports
`timescale 1ns/1ps
module ulmc_properties
  import ulmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [DATA_W-1:0] rdata,
  // pins and state
  input wire logic serial_out,
  input wire logic rts_n,
  input wire logic dtr_n,
  input wire logic irq_req,
  input wire logic host_interrupt_line_o,
  input wire logic host_interrupt_line_oe_n,
  input wire logic divisor_access_select,
  input wire logic loopback
);
  logic [7:0] lfc_r;
  logic [7:0] mlc_r;
  wire wr_lfc = wr_stb && addr == OFS_LFC;
  wire wr_mlc = wr_stb && addr == OFS_MLC;
  wire brk_on = lfc_r[6] && !mlc_r[MLC_LOOP];
  wire rd_reg = rd_stb && (addr == OFS_LFC || addr == OFS_MLC);
  // shadow copies of the two control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfc_r <= LFC_RST;
      mlc_r <= MLC_RST;
    end else if (wr_lfc) begin
      lfc_r <= wdata;
    end else if (wr_mlc) begin
      mlc_r <= wdata & MLC_WR_MASK;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // register then output flop: pins settle two edges after the write
  a_divsel_follow: assert property (wr_lfc |-> ##2
    divisor_access_select == $past(wdata[7], 2)) else $error("divisor select wrong");
  a_loop_follow: assert property (wr_mlc |-> ##2
    loopback == $past(wdata[MLC_LOOP], 2)) else $error("loopback wrong");
  a_rts_follow: assert property (wr_mlc |-> ##2
    rts_n == !$past(wdata[MLC_RTS], 2)) else $error("rts wrong");
  a_dtr_follow: assert property (wr_mlc |-> ##2
    dtr_n == !$past(wdata[MLC_DTR], 2)) else $error("dtr wrong");
  a_gate_follow: assert property (wr_mlc |-> ##2
    host_interrupt_line_oe_n == !$past(wdata[MLC_IRQ_GATE], 2)) else $error("gate wrong");
  a_irq_copy: assert property ($past(rst_n) |->
    host_interrupt_line_o == $past(irq_req)) else $error("irq copy wrong");
  a_break_space: assert property (brk_on && $past(brk_on) |->
    !serial_out) else $error("break not space");
  a_loop_mark: assert property (mlc_r[MLC_LOOP] && $past(mlc_r[MLC_LOOP]) |->
    serial_out) else $error("loop output not mark");
  a_reg_readback: assert property (rd_reg |=>
    rdata == ($past(addr) == OFS_LFC ? lfc_r : mlc_r)) else $error("readback wrong");
  cover property (wr_mlc && wdata[MLC_LOOP]);
  cover property (brk_on [*3]);
  cover property (rd_reg);
endmodule

bind ulmc_core ulmc_properties chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .serial_out(serial_out), .rts_n(rts_n),
  .dtr_n(dtr_n), .irq_req(irq_req), .host_interrupt_line_o(host_interrupt_line_o),
  .host_interrupt_line_oe_n(host_interrupt_line_oe_n),
  .divisor_access_select(divisor_access_select), .loopback(loopback));
